// ===== pkg/sfw_consts.svh
`ifndef SFW_CONSTS_SVH
`define SFW_CONSTS_SVH

// register byte offsets on the bus
`define SFW_OFS_STATUS 12'h000
`define SFW_OFS_BANK 12'h004

// bit positions inside the status word
`define SFW_BIT_UFA 5
`define SFW_BIT_BSH 4
`define SFW_BIT_BSL 3
`define SFW_BIT_RANGE 2
`define SFW_BIT_UFB 1
`define SFW_BIT_PAR 0

// reset values
`define SFW_STATUS_RST 8'h00
`define SFW_BANK_RST 2'h0
`define SFW_BASE_RST 5'h00
`define SFW_RDATA_RST 32'h0000_0000

// low address bits inside one bank of eight working registers
`define SFW_BANK_LOW 3'h0

// largest product that still fits in one byte
`define SFW_PRODUCT_MAX 16'h00ff

// divisor value that makes a quotient undefined
`define SFW_DIVISOR_ZERO 8'h00

`endif

// ===== pkg/sfw_pkg.sv
package sfw_pkg;

	// arithmetic operation reported by the core datapath
	typedef enum logic [2:0] {
		SFW_OP_NONE,
		SFW_OP_ADD,
		SFW_OP_ADD_CARRY,
		SFW_OP_SUB_BORROW,
		SFW_OP_PRODUCT,
		SFW_OP_DIV
	} sfw_op_kind_t;

	// one finished operation with its intermediate results
	typedef struct packed {
		sfw_op_kind_t kind; // operation type, none when idle
		logic cb6; // carry out of, or borrow into, bit 6
		logic cb7; // carry out of, or borrow into, bit 7
		logic [15:0] product; // full product of a product operation
		logic [7:0] divisor; // second operand before a quotient operation
	} sfw_op_t;

	// register bus slave states
	typedef enum logic {
		SFW_BUS_IDLE,
		SFW_BUS_ACCESS
	} sfw_bus_state_t;

endpackage

// ===== rtl/sfw_range_calc.sv
`timescale 1ns/100ps
`include "sfw_consts.svh"

// works out the signed range flag for one finished operation
module sfw_range_calc (
	// operation from the datapath
	input wire sfw_pkg::sfw_op_t op,
	// flag update
	output logic update,
	output logic value
);
	import sfw_pkg::*;

	// pick the flag rule by operation type
	always_comb begin
		update = 1'b1;
		value = 1'b0;
		case (op.kind)
			SFW_OP_ADD, SFW_OP_ADD_CARRY: begin
				// exactly one of the two carries
				value = op.cb6 ^ op.cb7;
			end
			SFW_OP_SUB_BORROW: begin
				// exactly one of the two borrows
				value = op.cb6 ^ op.cb7;
			end
			SFW_OP_PRODUCT: begin
				// product no longer fits in one byte
				value = op.product > `SFW_PRODUCT_MAX;
			end
			SFW_OP_DIV: begin
				// zero divisor, otherwise cleared
				value = op.divisor == `SFW_DIVISOR_ZERO;
			end
			default: begin
				// no operation leaves the flag alone
				update = 1'b0;
			end
		endcase
	end

endmodule

// ===== rtl/sfw_status_word.sv
// Decided for this implementation: the register addresses and the APB register port.
`timescale 1ns/100ps
`include "sfw_consts.svh"

module sfw_status_word #(
	parameter int ADDR_W = 12
) (
	// clock and reset
	input wire logic clk,
	input wire logic reset,
	// register bus
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [ADDR_W-1:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [3:0] pstrb,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// core datapath
	input wire sfw_pkg::sfw_op_t op,
	input wire logic [7:0] acc_value,
	// status word fields
	output logic user_flag_a,
	output logic [1:0] bank_select,
	output logic signed_range_flag,
	output logic user_flag_b,
	output logic parity_flag,
	// base address of the working registers
	output logic [4:0] bank_base_addr
);
	import sfw_pkg::*;

	// reset image of the whole word, the single-bit flag fields are picked out bit by bit
	localparam logic [7:0] STATUS_RST = `SFW_STATUS_RST;

	// bus slave state
	sfw_bus_state_t state;
	// setup phase seen in idle
	logic bus_setup;
	// transfer completes at this edge
	logic bus_done;
	// address decode
	logic hit_status;
	logic hit_bank;
	// software write to the status word
	logic wr_status;
	// read mux result
	logic [31:0] next_rdata;
	// unmapped access
	logic next_err;
	// next bank selection
	logic [1:0] next_bank_select;
	// flag update from the datapath
	logic hw_update;
	logic hw_value;

	// overflow rules per operation
	sfw_range_calc u_calc (
		.op(op),
		.update(hw_update),
		.value(hw_value)
	);

	// bus phase strobes
	assign bus_setup = (state == SFW_BUS_IDLE) && psel && !penable;
	assign bus_done = psel && penable && pready;

	// address decode
	always_comb begin
		hit_status = 1'b0;
		hit_bank = 1'b0;
		if (paddr == ADDR_W'(`SFW_OFS_STATUS)) begin
			hit_status = 1'b1;
		end else if (paddr == ADDR_W'(`SFW_OFS_BANK)) begin
			hit_bank = 1'b1;
		end
	end

	// write only lands with the low byte lane enabled
	assign wr_status = bus_done && pwrite && hit_status && pstrb[0];

	// read data for the addressed register
	always_comb begin
		next_rdata = `SFW_RDATA_RST;
		next_err = 1'b0;
		if (hit_status) begin
			next_rdata[`SFW_BIT_UFA] = user_flag_a;
			next_rdata[`SFW_BIT_BSH] = bank_select[1];
			next_rdata[`SFW_BIT_BSL] = bank_select[0];
			next_rdata[`SFW_BIT_RANGE] = signed_range_flag;
			next_rdata[`SFW_BIT_UFB] = user_flag_b;
			next_rdata[`SFW_BIT_PAR] = parity_flag;
		end else if (hit_bank) begin
			next_rdata[4:0] = bank_base_addr;
		end else begin
			// unmapped address answers with an error
			next_err = 1'b1;
		end
	end

	// bus slave: answer one cycle after setup, no wait states
	always_ff @(posedge clk) begin
		if (reset) begin
			state <= SFW_BUS_IDLE;
			pready <= 1'b0;
		end else begin
			case (state)
				SFW_BUS_IDLE: begin
					if (bus_setup) begin
						state <= SFW_BUS_ACCESS;
						pready <= 1'b1;
					end
				end
				SFW_BUS_ACCESS: begin
					// access always ends in this cycle
					state <= SFW_BUS_IDLE;
					pready <= 1'b0;
				end
				default: begin
					state <= SFW_BUS_IDLE;
					pready <= 1'b0;
				end
			endcase
		end
	end

	// read data and error latched at setup
	always_ff @(posedge clk) begin
		if (reset) begin
			prdata <= `SFW_RDATA_RST;
			pslverr <= 1'b0;
		end else if (bus_setup) begin
			prdata <= pwrite ? `SFW_RDATA_RST : next_rdata;
			pslverr <= next_err;
		end else if (bus_done) begin
			prdata <= `SFW_RDATA_RST;
			pslverr <= 1'b0;
		end
	end

	// user flag a: only software touches it
	always_ff @(posedge clk) begin
		if (reset) begin
			user_flag_a <= STATUS_RST[`SFW_BIT_UFA];
		end else if (wr_status) begin
			user_flag_a <= pwdata[`SFW_BIT_UFA];
		end
	end

	// user flag b: only software touches it
	always_ff @(posedge clk) begin
		if (reset) begin
			user_flag_b <= STATUS_RST[`SFW_BIT_UFB];
		end else if (wr_status) begin
			user_flag_b <= pwdata[`SFW_BIT_UFB];
		end
	end

	// bank selection follows a software write
	assign next_bank_select = wr_status ?
		{pwdata[`SFW_BIT_BSH], pwdata[`SFW_BIT_BSL]} : bank_select;

	// bank select and the matching working register base
	always_ff @(posedge clk) begin
		if (reset) begin
			bank_select <= `SFW_BANK_RST;
			bank_base_addr <= `SFW_BASE_RST;
		end else begin
			bank_select <= next_bank_select;
			bank_base_addr <= {next_bank_select, `SFW_BANK_LOW};
		end
	end

	// signed range flag: datapath result wins over a software write
	always_ff @(posedge clk) begin
		if (reset) begin
			signed_range_flag <= STATUS_RST[`SFW_BIT_RANGE];
		end else if (hw_update) begin
			signed_range_flag <= hw_value;
		end else if (wr_status) begin
			signed_range_flag <= pwdata[`SFW_BIT_RANGE];
		end
	end

	// parity of the accumulator, rebuilt every cycle, never written
	always_ff @(posedge clk) begin
		if (reset) begin
			parity_flag <= STATUS_RST[`SFW_BIT_PAR];
		end else begin
			parity_flag <= ^acc_value;
		end
	end

	// checks, sampled on the core clock
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (reset);

	// flag a holds without a write, takes the written bit with one
	property p_flag_a;
		wr_status |=> user_flag_a == $past(pwdata[`SFW_BIT_UFA]);
	endproperty
	a_flag_a: assert property (p_flag_a) else $error("flag a write lost");

	property p_flag_a_hold;
		!wr_status |=> $stable(user_flag_a);
	endproperty
	a_flag_a_hold: assert property (p_flag_a_hold) else $error("flag a moved");

	// base address always matches the selected bank
	property p_bank_base;
		bank_base_addr == {bank_select, `SFW_BANK_LOW};
	endproperty
	a_bank_base: assert property (p_bank_base) else $error("bank base wrong");

	// sum operations
	property p_sum;
		(op.kind == SFW_OP_ADD || op.kind == SFW_OP_ADD_CARRY)
			|=> signed_range_flag == ($past(op.cb6) ^ $past(op.cb7));
	endproperty
	a_sum: assert property (p_sum) else $error("sum overflow wrong");

	// difference operation
	property p_diff;
		op.kind == SFW_OP_SUB_BORROW
			|=> signed_range_flag == ($past(op.cb6) ^ $past(op.cb7));
	endproperty
	a_diff: assert property (p_diff) else $error("borrow overflow wrong");

	// product operation
	property p_prod;
		op.kind == SFW_OP_PRODUCT
			|=> signed_range_flag == ($past(op.product) > `SFW_PRODUCT_MAX);
	endproperty
	a_prod: assert property (p_prod) else $error("product overflow wrong");

	// quotient operation
	property p_quot;
		op.kind == SFW_OP_DIV
			|=> signed_range_flag == ($past(op.divisor) == `SFW_DIVISOR_ZERO);
	endproperty
	a_quot: assert property (p_quot) else $error("quotient flag wrong");

	// flag b holds without a write, takes the written bit with one
	property p_flag_b;
		wr_status |=> user_flag_b == $past(pwdata[`SFW_BIT_UFB]);
	endproperty
	a_flag_b: assert property (p_flag_b) else $error("flag b write lost");

	property p_flag_b_hold;
		!wr_status |=> $stable(user_flag_b);
	endproperty
	a_flag_b_hold: assert property (p_flag_b_hold) else $error("flag b moved");

	// parity trails the accumulator by one cycle
	property p_parity;
		!reset |=> parity_flag == ^$past(acc_value);
	endproperty
	a_parity: assert property (p_parity) else $error("parity wrong");

	// reset clears every field of the word
	property p_reset;
		@(posedge clk) disable iff (1'b0)
		reset |=> !user_flag_a && bank_select == `SFW_BANK_RST
			&& !signed_range_flag && !user_flag_b && !parity_flag;
	endproperty
	a_reset: assert property (p_reset) else $error("reset not clear");

	// a write never forces the parity bit
	property p_parity_write;
		wr_status && (pwdata[`SFW_BIT_PAR] != ^acc_value)
			|=> parity_flag != $past(pwdata[`SFW_BIT_PAR]);
	endproperty
	a_parity_write: assert property (p_parity_write) else $error("parity written");

	// bus answers in the cycle after setup
	property p_bus_answer;
		bus_setup |=> pready ##1 !pready;
	endproperty
	a_bus_answer: assert property (p_bus_answer) else $error("bus answer late");

	// an unmapped place answers with an error flag
	property p_bus_error;
		bus_setup && !hit_status && !hit_bank |=> pready && pslverr;
	endproperty
	a_bus_error: assert property (p_bus_error) else $error("unmapped access not refused");

	// main scenarios
	c_sum_ovf: cover property (op.kind == SFW_OP_ADD && op.cb6 && !op.cb7 ##1 signed_range_flag);
	c_div_zero: cover property (op.kind == SFW_OP_DIV && op.divisor == `SFW_DIVISOR_ZERO);
	c_bank3: cover property (bank_select == 2'h3);
	c_prod_ovf: cover property (op.kind == SFW_OP_PRODUCT && op.product > `SFW_PRODUCT_MAX);
	c_sw_write: cover property (wr_status ##1 user_flag_a && user_flag_b);

endmodule

// ===== sim/sfw_status_word_tb.sv
`timescale 1ns/100ps
`include "sfw_consts.svh"

// self-checking bench for the status word block
module sfw_status_word_tb;
	import sfw_pkg::*;
	// clock, reset and register bus
	logic clk = 1'b0;
	logic reset = 1'b1;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0000_0000;
	logic [3:0] pstrb = 4'h0;
	logic [31:0] prdata;
	logic pready;
	logic pslverr;
	// datapath side
	sfw_op_t op = '0;
	logic [7:0] acc_value = 8'h00;
	// status word fields
	logic user_flag_a;
	logic [1:0] bank_select;
	logic signed_range_flag;
	logic user_flag_b;
	logic parity_flag;
	logic [4:0] bank_base_addr;
	// bookkeeping
	int bad_count = 0;
	int checked = 0;
	int cycles = 0;
	logic [31:0] rd; // last read data
	logic err; // last error response
	logic [7:0] pv [7] = '{8'h00, 8'h01, 8'h03, 8'h80, 8'hfe, 8'hff, 8'h7f};

	sfw_status_word #(.ADDR_W(12)) u_dut (
		.clk(clk), .reset(reset),
		.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
		.pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .op(op), .acc_value(acc_value),
		.user_flag_a(user_flag_a), .bank_select(bank_select),
		.signed_range_flag(signed_range_flag), .user_flag_b(user_flag_b),
		.parity_flag(parity_flag), .bank_base_addr(bank_base_addr)
	);

	// 100 mhz clock
	initial begin
		forever #5 clk = ~clk;
	end

	// hang guard, far above the length of the sequence
	always @(posedge clk) begin
		cycles <= cycles + 1;
		if (cycles == 5000) begin
			bad_count++;
			report_and_stop();
		end
	end

	// verdict and end of run
	task automatic report_and_stop;
		if (bad_count == 0 && checked > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask

	// one comparison
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checked++;
		if (got !== exp) begin
			bad_count++;
			$display("BAD %0t got %h expected %h", $time, got, exp);
		end
	endtask

	// one apb transfer: setup, then access held until pready is sampled
	task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d,
		input logic [3:0] s);
		@(posedge clk);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		pstrb <= s;
		@(posedge clk);
		penable <= 1'b1;
		do begin
			@(posedge clk);
		end while (pready !== 1'b1);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	// one datapath operation held for one cycle, then the flag is compared
	task automatic do_op(input sfw_op_kind_t k, input logic c6, input logic c7,
		input logic [15:0] pr, input logic [7:0] dv, input logic e);
		@(posedge clk);
		op <= '{kind: k, cb6: c6, cb7: c7, product: pr, divisor: dv};
		@(posedge clk);
		op.kind <= SFW_OP_NONE;
		#1;
		chk({31'h0, signed_range_flag}, {31'h0, e});
	endtask

	// main sequence
	initial begin
		repeat (2) @(posedge clk);
		reset <= 1'b0;
		apb(1'b0, `SFW_OFS_STATUS, 32'h0, 4'h0);
		chk(rd, 32'h0);
		apb(1'b0, `SFW_OFS_BANK, 32'h0, 4'h0);
		chk(rd, 32'h0);
		// all bits written high: parity and unused bits must stay low
		apb(1'b1, `SFW_OFS_STATUS, 32'hffff_ffff, 4'hf);
		apb(1'b0, `SFW_OFS_STATUS, 32'h0, 4'h0);
		chk(rd, 32'h0000_003e);
		// every bank value, seen on the port and through the bank register
		for (int b = 0; b < 4; b++) begin
			apb(1'b1, `SFW_OFS_STATUS, 32'(b << 3), 4'h1);
			#1;
			chk({27'h0, bank_base_addr}, 32'(b * 8));
			apb(1'b0, `SFW_OFS_BANK, 32'h0, 4'h0);
			chk(rd, 32'(b * 8));
		end
		// user flags one at a time
		apb(1'b1, `SFW_OFS_STATUS, 32'h0000_0020, 4'h1);
		#1;
		chk({30'h0, user_flag_a, user_flag_b}, 32'h2);
		apb(1'b1, `SFW_OFS_STATUS, 32'h0000_0022, 4'h1);
		#1;
		chk({30'h0, user_flag_a, user_flag_b}, 32'h3);
		// refused writes: low byte lane strobe off, read-only bank register, unmapped place
		apb(1'b1, `SFW_OFS_STATUS, 32'h0, 4'he);
		apb(1'b1, `SFW_OFS_BANK, 32'h0000_001f, 4'hf);
		chk({31'h0, err}, 32'h0);
		apb(1'b1, 12'h00c, 32'h0, 4'hf);
		chk({31'h0, err}, 32'h1);
		apb(1'b0, 12'h008, 32'h0, 4'h0);
		chk({31'h0, err}, 32'h1);
		chk(rd, 32'h0);
		apb(1'b0, `SFW_OFS_STATUS, 32'h0, 4'h0);
		chk(rd, 32'h0000_0022);
		// sum, sum with carry and difference: every carry pairing
		for (int i = 0; i < 12; i++) begin
			do_op(i < 4 ? SFW_OP_ADD : i < 8 ? SFW_OP_ADD_CARRY : SFW_OP_SUB_BORROW,
				i[0], i[1], 16'h0, 8'h01, i[0] ^ i[1]);
		end
		// product around the byte limit, carries ignored
		do_op(SFW_OP_PRODUCT, 1'b1, 1'b0, 16'h0100, 8'h01, 1'b1);
		do_op(SFW_OP_PRODUCT, 1'b1, 1'b0, 16'h00ff, 8'h01, 1'b0);
		do_op(SFW_OP_PRODUCT, 1'b0, 1'b0, 16'hffff, 8'h01, 1'b1);
		// quotient with and without a zero divisor
		do_op(SFW_OP_DIV, 1'b1, 1'b0, 16'h0, 8'h05, 1'b0);
		do_op(SFW_OP_DIV, 1'b0, 1'b0, 16'h0, 8'h00, 1'b1);
		do_op(SFW_OP_DIV, 1'b0, 1'b1, 16'h0, 8'h80, 1'b0);
		do_op(SFW_OP_DIV, 1'b0, 1'b0, 16'h0, 8'h00, 1'b1);
		// flags untouched by the operations, range flag left set
		apb(1'b0, `SFW_OFS_STATUS, 32'h0, 4'h0);
		chk(rd, 32'h0000_0026);
		// parity follows the accumulator
		foreach (pv[j]) begin
			@(posedge clk);
			acc_value <= pv[j];
			repeat (2) @(posedge clk);
			#1;
			chk({31'h0, parity_flag}, {31'h0, ^pv[j]});
		end
		// clearing writes leave the parity bit alone
		apb(1'b1, `SFW_OFS_STATUS, 32'h0, 4'h1);
		apb(1'b0, `SFW_OFS_STATUS, 32'h0, 4'h0);
		chk(rd, 32'h0000_0001);
		// mid-run reset clears every field, parity included, while it is held
		apb(1'b1, `SFW_OFS_STATUS, 32'h0000_003e, 4'h1);
		@(posedge clk);
		reset <= 1'b1;
		repeat (2) @(posedge clk);
		#1;
		rd = {21'h0, user_flag_a, bank_select, signed_range_flag, user_flag_b, parity_flag,
			bank_base_addr};
		chk(rd, 32'h0);
		@(posedge clk);
		reset <= 1'b0;
		// after release the parity bit comes back from the accumulator
		apb(1'b0, `SFW_OFS_STATUS, 32'h0, 4'h0);
		chk(rd, 32'h0000_0001);
		report_and_stop();
	end
endmodule
